// file: rtl/tcp_consts.vh
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH

// register byte offsets
`define TCP_OFF_CMP1_HI   8'h00
`define TCP_OFF_CMP1_LO   8'h04
`define TCP_OFF_CMP2_HI   8'h08
`define TCP_OFF_CMP2_LO   8'h0C
`define TCP_OFF_CTRL_A    8'h10
`define TCP_OFF_CTRL_B    8'h14
`define TCP_OFF_CTRL_C    8'h18
`define TCP_OFF_STATUS    8'h1C
`define TCP_OFF_COUNT     8'h20
`define TCP_OFF_CAPT      8'h24

// timer_control_a fields
`define TCP_CA_LVL1       0
`define TCP_CA_LVL2       1
`define TCP_CA_FRC1       2
`define TCP_CA_FRC2       3
`define TCP_CA_EDGE1      4
`define TCP_CA_CMP_IE     5
`define TCP_CA_CAP_IE     6
`define TCP_CA_OVF_IE     7

// timer_control_b fields
`define TCP_CB_PEN1       0
`define TCP_CB_PEN2       1
`define TCP_CB_OPM        2
`define TCP_CB_PWM        3
`define TCP_CB_PSC_LO     4
`define TCP_CB_PSC_HI     5

// timer_control_c fields
`define TCP_CC_CAP_SRC    0
`define TCP_CC_CMP_SRC    1
`define TCP_CC_OVF_SRC    2
`define TCP_CC_GLB        3

// timer_status_reg fields
`define TCP_ST_CMP1       0
`define TCP_ST_CMP2       1
`define TCP_ST_CAP        2
`define TCP_ST_OVF        3

// reset values and counter constants
`define TCP_CMP_RST       16'h8000
`define TCP_CNT_RELOAD    16'hFFFC
`define TCP_CNT_TOP       16'hFFFF
`define TCP_CTRL_RST      8'h00

// prescaler terminal counts (divide by 2, 4, 8)
`define TCP_DIV2_MAX      3'h1
`define TCP_DIV4_MAX      3'h3
`define TCP_DIV8_MAX      3'h7

// bus responses
`define TCP_RESP_OKAY     2'h0
`define TCP_RESP_SLVERR   2'h2

`endif

// file: rtl/tcp_count.v
`timescale 1ns/1ns
`include "tcp_consts.vh"

module tcp_count (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [1:0]  prescale_select,
  input  wire        reload,
  output wire        tick,
  output reg  [15:0] count_r
);

  reg [2:0] div_r;
  reg [2:0] div_max;

  always @* begin
    case (prescale_select)
      2'h0:    div_max = `TCP_DIV2_MAX;
      2'h1:    div_max = `TCP_DIV4_MAX;
      default: div_max = `TCP_DIV8_MAX;
    endcase
  end

  assign tick = (div_r >= div_max);

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_r   <= 3'h0;
      count_r <= `TCP_CNT_RELOAD;
    end else begin
      if (tick) begin
        div_r <= 3'h0;
      end else begin
        div_r <= div_r + 3'h1;
      end
      if (reload) begin
        count_r <= `TCP_CNT_RELOAD;
      end else if (tick) begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

endmodule // tcp_count

// file: rtl/tcp_top.v
// Contract
// - each timer tick, compare both 16-bit compare values to counter; match sets flag
// - reset loads both compare values with 8000h; only software changes them
// - pin enable bit gives the compare pin to the compare function
// - enabled match drives programmed level; pin latch low from reset until match
// - compare request needs irq enable and source select or global select
// - status read with flag set, then low byte access, clears flag
// - high byte write blocks matches until low byte is written
// - pin enable clear: pin stays general, interrupt still possible
// - force bit with pin enabled copies level bit straight to pin
// - forced compare sets no flag and requests no interrupt
// - single pulse: capture edge reloads FFFCh, drives level two on pin one
// - single pulse: compare one match drives level one on pin one
// - single pulse: compare flag one never set; flag two still works
// - single pulse: capture flag still set, interrupt when capture enabled
// - pwm and single pulse both set means pwm only
// - pwm: match one drives level one, match two level two, pin one
// - pwm: compare two match reloads counter with FFFCh
// - pwm: no compare flags set; capture interrupts remain
// - global select clear gives three request lines; set gives one
// - compare resolution is one counter count at prescaled clock
// - prescaler divides internal clock by 2, 4 or 8
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "tcp_consts.vh"

module tcp_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        capture_input_one,
  output wire        compare_output_pin_one,
  output wire        compare_output_pin_one_oe_n,
  output wire        compare_output_pin_two,
  output wire        compare_output_pin_two_oe_n,
  output wire        irq_capture,
  output wire        irq_compare,
  output wire        irq_overflow,
  output wire        irq_global
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg         awready_r;
  reg         wready_r;
  reg         bvalid_r;
  reg  [1:0]  bresp_r;
  reg         arready_r;
  reg         rvalid_r;
  reg  [1:0]  rresp_r;
  reg  [31:0] rdata_r;
  reg         aw_full_r;
  reg         w_full_r;
  reg  [7:0]  aw_addr_r;
  reg  [7:0]  w_data_r;
  reg         w_lane_r;

  reg  [15:0] cmp_r [0:1];
  reg  [1:0]  inh_r;
  reg  [7:0]  ctrl_a_r;
  reg  [7:0]  ctrl_b_r;
  reg  [7:0]  ctrl_c_r;
  reg  [3:0]  flag_r;
  reg  [3:0]  arm_r;
  reg  [15:0] capt_r;

  reg         cap_s1_r;
  reg         cap_s2_r;
  reg         cap_s3_r;
  reg         cap_lvl_r;

  reg         pin1_r;
  reg         pin2_r;
  reg         pin1_oe_n_r;
  reg         pin2_oe_n_r;
  reg         irq_cap_r;
  reg         irq_cmp_r;
  reg         irq_ovf_r;
  reg         irq_glb_r;

  reg         pin1_nxt;
  reg         pin2_nxt;
  reg  [31:0] rd_nxt;
  reg         rd_ok;
  reg         wr_ok;

  wire        tick;
  wire [15:0] count;
  wire        reload;
  wire        aw_take;
  wire        w_take;
  wire        ar_take;
  wire        wr_go;
  wire        wr_en;
  wire [1:0]  wr_hi;
  wire [1:0]  wr_lo;
  wire [1:0]  rd_lo;
  wire [1:0]  match;
  wire [3:0]  acc;
  wire [3:0]  flag_set;
  wire [3:0]  flag_clr;
  wire        st_rd;
  wire        cap_edge;
  wire        pwm;
  wire        single_pulse_select;
  wire        glb;
  wire        pend_cap;
  wire        pend_cmp;
  wire        pend_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // counter and prescaler

  tcp_count u_count (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .prescale_select (ctrl_b_r[`TCP_CB_PSC_HI:`TCP_CB_PSC_LO]),
    .reload          (reload),
    .tick            (tick),
    .count_r         (count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus write channel

  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take  = s_axi_wvalid & wready_r;
  assign wr_go   = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_en   = wr_go & wr_ok & w_lane_r;

  always @* begin
    case (aw_addr_r)
      `TCP_OFF_CMP1_HI, `TCP_OFF_CMP1_LO, `TCP_OFF_CMP2_HI, `TCP_OFF_CMP2_LO,
      `TCP_OFF_CTRL_A, `TCP_OFF_CTRL_B, `TCP_OFF_CTRL_C, `TCP_OFF_COUNT,
      `TCP_OFF_STATUS, `TCP_OFF_CAPT: wr_ok = 1'b1;
      default:                        wr_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `TCP_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
        awready_r <= 1'b1;
      end else begin
        awready_r <= ~aw_full_r;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
        wready_r <= 1'b0;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
        wready_r <= 1'b1;
      end else begin
        wready_r <= ~w_full_r;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_ok ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read channel

  assign ar_take = s_axi_arvalid & arready_r;

  always @* begin
    rd_nxt = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `TCP_OFF_CMP1_HI: rd_nxt[7:0]  = cmp_r[0][15:8];
      `TCP_OFF_CMP1_LO: rd_nxt[7:0]  = cmp_r[0][7:0];
      `TCP_OFF_CMP2_HI: rd_nxt[7:0]  = cmp_r[1][15:8];
      `TCP_OFF_CMP2_LO: rd_nxt[7:0]  = cmp_r[1][7:0];
      `TCP_OFF_CTRL_A:  rd_nxt[7:0]  = ctrl_a_r;
      `TCP_OFF_CTRL_B:  rd_nxt[7:0]  = ctrl_b_r;
      `TCP_OFF_CTRL_C:  rd_nxt[7:0]  = ctrl_c_r;
      `TCP_OFF_STATUS:  rd_nxt[3:0]  = flag_r;
      `TCP_OFF_COUNT:   rd_nxt[15:0] = count;
      `TCP_OFF_CAPT:    rd_nxt[15:0] = capt_r;
      default:          rd_ok        = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= `TCP_RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      if (ar_take) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_nxt;
        rresp_r   <= rd_ok ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      end else if (!rvalid_r || s_axi_rready) begin
        arready_r <= 1'b1;
        rvalid_r  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access strobes

  assign wr_hi = {wr_en & (aw_addr_r == `TCP_OFF_CMP2_HI),
                  wr_en & (aw_addr_r == `TCP_OFF_CMP1_HI)};
  assign wr_lo = {wr_en & (aw_addr_r == `TCP_OFF_CMP2_LO),
                  wr_en & (aw_addr_r == `TCP_OFF_CMP1_LO)};
  assign rd_lo = {ar_take & (s_axi_araddr == `TCP_OFF_CMP2_LO),
                  ar_take & (s_axi_araddr == `TCP_OFF_CMP1_LO)};
  assign st_rd = ar_take & (s_axi_araddr == `TCP_OFF_STATUS);

  assign acc[`TCP_ST_CMP1] = wr_lo[0] | rd_lo[0];
  assign acc[`TCP_ST_CMP2] = wr_lo[1] | rd_lo[1];
  assign acc[`TCP_ST_CAP]  = (ar_take & (s_axi_araddr == `TCP_OFF_CAPT)) |
                             (wr_go & (aw_addr_r == `TCP_OFF_CAPT));
  assign acc[`TCP_ST_OVF]  = (ar_take & (s_axi_araddr == `TCP_OFF_COUNT)) |
                             (wr_go & (aw_addr_r == `TCP_OFF_COUNT));

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_r <= `TCP_CTRL_RST;
      ctrl_b_r <= `TCP_CTRL_RST;
      ctrl_c_r <= `TCP_CTRL_RST;
    end else if (wr_en) begin
      case (aw_addr_r)
        `TCP_OFF_CTRL_A: ctrl_a_r <= w_data_r;
        `TCP_OFF_CTRL_B: ctrl_b_r <= w_data_r;
        `TCP_OFF_CTRL_C: ctrl_c_r <= w_data_r;
        default:         ctrl_a_r <= ctrl_a_r;
      endcase
    end
  end

  assign pwm = ctrl_b_r[`TCP_CB_PWM];
  assign single_pulse_select = ctrl_b_r[`TCP_CB_OPM] & ~pwm;
  assign glb = ctrl_c_r[`TCP_CC_GLB];

  ////////////////////////////////////////////////////////////////////////////
  // compare channels

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
      always @(posedge aclk) begin
        if (!aresetn) begin
          cmp_r[gi] <= `TCP_CMP_RST;
          inh_r[gi] <= 1'b0;
        end else if (wr_hi[gi]) begin
          cmp_r[gi][15:8] <= w_data_r;
          inh_r[gi]       <= 1'b1;
        end else if (wr_lo[gi]) begin
          cmp_r[gi][7:0] <= w_data_r;
          inh_r[gi]      <= 1'b0;
        end
      end
      // checked once per counter step
      assign match[gi] = tick & ~inh_r[gi] & (count == cmp_r[gi]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // capture input, three-stage synchroniser

  always @(posedge aclk) begin
    if (!aresetn) begin
      cap_s1_r  <= 1'b0;
      cap_s2_r  <= 1'b0;
      cap_s3_r  <= 1'b0;
      cap_lvl_r <= 1'b0;
      capt_r    <= 16'h0000;
    end else begin
      cap_s1_r <= capture_input_one;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
      if (cap_s2_r == cap_s3_r) begin
        cap_lvl_r <= cap_s2_r;
      end
      if (cap_edge) begin
        capt_r <= count;
      end
    end
  end

  // active edge: settled level changed toward the selected polarity
  assign cap_edge = (cap_s2_r == cap_s3_r) & (cap_s2_r != cap_lvl_r) &
                    (cap_s2_r == ctrl_a_r[`TCP_CA_EDGE1]);

  assign reload = (single_pulse_select & cap_edge) |
                  (pwm & match[1]) |
                  (wr_go & (aw_addr_r == `TCP_OFF_COUNT));

  ////////////////////////////////////////////////////////////////////////////
  // status flags, set wins over clear

  assign flag_set[`TCP_ST_CMP1] = match[0] & ~pwm & ~single_pulse_select;
  assign flag_set[`TCP_ST_CMP2] = match[1] & ~pwm;
  assign flag_set[`TCP_ST_CAP]  = cap_edge;
  assign flag_set[`TCP_ST_OVF]  = tick & (count == `TCP_CNT_TOP);
  assign flag_clr               = acc & arm_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 4'h0;
      arm_r  <= 4'h0;
    end else begin
      flag_r <= flag_set | (flag_r & ~flag_clr);
      if (st_rd) begin
        arm_r <= flag_r;
      end else begin
        arm_r <= arm_r & ~acc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare pins

  always @* begin
    pin1_nxt = pin1_r;
    pin2_nxt = pin2_r;
    if (ctrl_b_r[`TCP_CB_PEN1]) begin
      if (ctrl_a_r[`TCP_CA_FRC1]) begin
        pin1_nxt = ctrl_a_r[`TCP_CA_LVL1];
      end else if (pwm) begin
        if (match[1]) begin
          pin1_nxt = ctrl_a_r[`TCP_CA_LVL2];
        end else if (match[0]) begin
          pin1_nxt = ctrl_a_r[`TCP_CA_LVL1];
        end
      end else if (single_pulse_select) begin
        if (cap_edge) begin
          pin1_nxt = ctrl_a_r[`TCP_CA_LVL2];
        end else if (match[0]) begin
          pin1_nxt = ctrl_a_r[`TCP_CA_LVL1];
        end
      end else if (match[0]) begin
        pin1_nxt = ctrl_a_r[`TCP_CA_LVL1];
      end
    end
    if (ctrl_b_r[`TCP_CB_PEN2]) begin
      if (ctrl_a_r[`TCP_CA_FRC2]) begin
        pin2_nxt = ctrl_a_r[`TCP_CA_LVL2];
      end else if (match[1] & ~pwm) begin
        pin2_nxt = ctrl_a_r[`TCP_CA_LVL2];
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin1_r      <= 1'b0;
      pin2_r      <= 1'b0;
      pin1_oe_n_r <= 1'b1;
      pin2_oe_n_r <= 1'b1;
    end else begin
      pin1_r      <= pin1_nxt;
      pin2_r      <= pin2_nxt;
      pin1_oe_n_r <= ~ctrl_b_r[`TCP_CB_PEN1];
      pin2_oe_n_r <= ~ctrl_b_r[`TCP_CB_PEN2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt requests, pending until enables agree

  assign pend_cap = flag_r[`TCP_ST_CAP] & ctrl_a_r[`TCP_CA_CAP_IE];
  assign pend_cmp = (flag_r[`TCP_ST_CMP1] | flag_r[`TCP_ST_CMP2]) &
                    ctrl_a_r[`TCP_CA_CMP_IE];
  assign pend_ovf = flag_r[`TCP_ST_OVF] & ctrl_a_r[`TCP_CA_OVF_IE];

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_cap_r <= 1'b0;
      irq_cmp_r <= 1'b0;
      irq_ovf_r <= 1'b0;
      irq_glb_r <= 1'b0;
    end else begin
      irq_cap_r <= ~glb & ctrl_c_r[`TCP_CC_CAP_SRC] & pend_cap;
      irq_cmp_r <= ~glb & ctrl_c_r[`TCP_CC_CMP_SRC] & pend_cmp;
      irq_ovf_r <= ~glb & ctrl_c_r[`TCP_CC_OVF_SRC] & pend_ovf;
      irq_glb_r <= glb & (pend_cap | pend_cmp | pend_ovf);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready               = awready_r;
  assign s_axi_wready                = wready_r;
  assign s_axi_bresp                 = bresp_r;
  assign s_axi_bvalid                = bvalid_r;
  assign s_axi_arready               = arready_r;
  assign s_axi_rdata                 = rdata_r;
  assign s_axi_rresp                 = rresp_r;
  assign s_axi_rvalid                = rvalid_r;
  assign compare_output_pin_one      = pin1_r;
  assign compare_output_pin_one_oe_n = pin1_oe_n_r;
  assign compare_output_pin_two      = pin2_r;
  assign compare_output_pin_two_oe_n = pin2_oe_n_r;
  assign irq_capture                 = irq_cap_r;
  assign irq_compare                 = irq_cmp_r;
  assign irq_overflow                = irq_ovf_r;
  assign irq_global                  = irq_glb_r;

endmodule // tcp_top

// file: tb/tcp_monitor.sv
`timescale 1ns/1ns
module tcp_monitor (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire [7:0] s_axi_araddr,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire       s_axi_rvalid,
  input wire       compare_output_pin_one,
  input wire       compare_output_pin_one_oe_n,
  input wire       compare_output_pin_two,
  input wire       compare_output_pin_two_oe_n,
  input wire       irq_capture,
  input wire       irq_compare,
  input wire       irq_overflow,
  input wire       irq_global
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h28;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_state: assert property ($rose(aresetn) |->
    !compare_output_pin_one && !compare_output_pin_two && compare_output_pin_one_oe_n
    && compare_output_pin_two_oe_n) else $error("outputs not at reset state");
  a_write_resp: assert property (s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late or early");
  a_read_resp: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response not one cycle after address");
  a_read_err: assert property (s_rd_bad |=> s_axi_rresp == 2'h2)
    else $error("unmapped read without error response");
  a_oe_on_write: assert property ($changed(compare_output_pin_one_oe_n) |->
    $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("pin one enable moved without a write");
  a_pin1_gated: assert property ($changed(compare_output_pin_one) |->
    !compare_output_pin_one_oe_n) else $error("pin one moved while released");
  a_pin2_gated: assert property ($changed(compare_output_pin_two) |->
    !compare_output_pin_two_oe_n) else $error("pin two moved while released");
  a_irq_global: assert property (irq_global |->
    !irq_capture && !irq_compare && !irq_overflow) else $error("separate lines with global");
endmodule // tcp_monitor

bind tcp_top tcp_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .compare_output_pin_one(compare_output_pin_one),
  .compare_output_pin_one_oe_n(compare_output_pin_one_oe_n),
  .compare_output_pin_two(compare_output_pin_two),
  .compare_output_pin_two_oe_n(compare_output_pin_two_oe_n),
  .irq_capture(irq_capture), .irq_compare(irq_compare), .irq_overflow(irq_overflow),
  .irq_global(irq_global)
);

// file: tb/tcp_pin_load.sv
`timescale 1ns/1ns
module tcp_pin_load (
  input  wire aclk,
  input  wire pin,
  input  wire oe_n,
  output wire pad,
  output int  hi_len,
  output int  per_len
);
  int   run_h = 0;
  int   run_p = 0;
  logic last  = 1'b0;
  // released pin floats up to the pull-up
  assign pad = oe_n ? 1'b1 : pin;
  // last high time and last rise-to-rise period, in clocks
  always @(posedge aclk) begin
    last <= pad;
    run_h <= pad ? run_h + 1 : 0;
    run_p <= (pad && !last) ? 1 : run_p + 1;
    if (!pad && last) hi_len <= run_h;
    if (pad && !last) per_len <= run_p;
  end
endmodule // tcp_pin_load

// file: tb/tcp_top_tb.sv
`timescale 1ns/1ns
module tcp_top_tb;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, cap = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [1:0]  rs;
  logic [15:0] v;
  wire         awready, wready, bvalid, arready, rvalid, pad1;
  wire         pin1, oe1_n, pin2, oe2_n, irq_cap, irq_cmp, irq_ovf, irq_glb;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          hi_len, per_len, err_total = 0, tests_run = 0, cyc = 0, seed = 57, c, k;

  always #2 aclk = ~aclk;

  tcp_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_input_one(cap), .compare_output_pin_one(pin1),
    .compare_output_pin_one_oe_n(oe1_n), .compare_output_pin_two(pin2),
    .compare_output_pin_two_oe_n(oe2_n), .irq_capture(irq_cap), .irq_compare(irq_cmp),
    .irq_overflow(irq_ovf), .irq_global(irq_glb)
  );
  tcp_pin_load u_load (
    .aclk(aclk), .pin(pin1), .oe_n(oe1_n), .pad(pad1), .hi_len(hi_len), .per_len(per_len)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic int dv(input int p);
    return p == 0 ? 2 : p == 1 ? 4 : 8;
  endfunction
  function automatic logic [15:0] inw(input int x, input int lo, input int hi);
    return 16'(x >= lo && x <= hi);
  endfunction
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    logic aw, w, t1, t2;
    @(posedge aclk);
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1;
    wvalid <= 1;
    while (aw || w) begin
      @(negedge aclk);
      t1 = awready && aw;
      t2 = wready && w;
      @(posedge aclk);
      if (t1) awvalid <= 0;
      if (t1) aw = 0;
      if (t2) wvalid <= 0;
      if (t2) w = 0;
    end
    bready <= 1;
    do begin @(negedge aclk); t1 = bvalid; rs = bresp; @(posedge aclk); end while (!t1);
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    do begin @(negedge aclk); t = arready; @(posedge aclk); end while (!t);
    arvalid <= 0;
    rready <= 1;
    do begin @(negedge aclk); t = rvalid; rd = rdata; rs = rresp; @(posedge aclk); end while (!t);
    rready <= 0;
  endtask
  task automatic wpin(input logic e, input int lim);
    c = 0;
    while (pad1 !== e && c < lim) begin @(negedge aclk); c++; end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize;
    end
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (k = 0; k < 4; k++) begin
      axr(8'(k * 4));
      chk(16'(rd[7:0]), k[0] ? 16'h0000 : 16'h0080);
    end
    axr(8'h40);
    chk(16'(rs), 16'h0002);
    axw(8'h40, 8'h00);
    chk(16'(rs), 16'h0002);
    repeat (4) begin
      v = 16'($random(seed)) | 16'h8000;
      axw(8'h08, v[15:8]);
      axw(8'h0C, v[7:0]);
      axr(8'h08);
      chk(16'(rd[7:0]), 16'(v[15:8]));
      axr(8'h0C);
      chk(16'(rd[7:0]), 16'(v[7:0]));
    end
    axw(8'h08, 8'h80);
    axw(8'h0C, 8'h00);
    axw(8'h00, 8'h00);
    axw(8'h04, 8'h10);
    // one match per prescale code, level alternating
    for (k = 0; k < 4; k++) begin
      axw(8'h10, 8'(~k & 1));
      axw(8'h14, 8'(1 + k * 16));
      axw(8'h20, 8'h00);
      wpin(~k[0], 400);
      chk(inw(c, 20 * dv(k) + 1, 21 * dv(k)), 16'h0001);
    end
    axr(8'h1C);
    chk(16'({rd[0], irq_cmp}), 16'h0002);
    axw(8'h18, 8'h02);
    axw(8'h10, 8'h20);
    repeat (3) @(negedge aclk);
    chk(16'(irq_cmp), 16'h0001);
    axw(8'h18, 8'h0A);
    repeat (3) @(negedge aclk);
    chk(16'({irq_glb, irq_cmp, irq_cap, irq_ovf}), 16'h0008);
    axw(8'h18, 8'h02);
    axr(8'h1C);
    axr(8'h04);
    axr(8'h1C);
    chk(16'({rd[0], irq_cmp}), 16'h0000);
    // high byte alone keeps compares off
    axw(8'h00, 8'h00);
    axr(8'h1C);
    axw(8'h10, 8'h21);
    axw(8'h20, 8'h00);
    wpin(1'b1, 200);
    chk(16'(pad1), 16'h0000);
    axw(8'h04, 8'h10);
    axw(8'h20, 8'h00);
    wpin(1'b1, 200);
    chk(16'(pad1), 16'h0001);
    axr(8'h1C);
    axr(8'h04);
    // pin released: no level, flag and request still come
    axw(8'h14, 8'h30);
    axw(8'h10, 8'h20);
    axw(8'h20, 8'h00);
    repeat (200) @(negedge aclk);
    chk(16'({pad1, pin1, irq_cmp}), 16'h0007);
    axr(8'h1C);
    chk(16'(rd[0]), 16'h0001);
    axr(8'h04);
    axw(8'h14, 8'h33);
    axw(8'h10, 8'h2F);
    repeat (4) @(negedge aclk);
    chk(16'({pin1, pin2}), 16'h0003);
    axw(8'h10, 8'h2C);
    repeat (4) @(negedge aclk);
    chk(16'({pin1, pin2, irq_cmp}), 16'h0000);
    axr(8'h1C);
    chk(16'(rd[1:0]), 16'h0000);
    // single pulse from a rising capture edge
    axw(8'h04, 8'h08);
    axw(8'h18, 8'h01);
    axw(8'h10, 8'h52);
    axw(8'h14, 8'h05);
    cap <= 1;
    wpin(1'b1, 50);
    wpin(1'b0, 100);
    repeat (2) @(negedge aclk);
    chk(inw(hi_len, 23, 27), 16'h0001);
    axr(8'h1C);
    chk(16'({rd[2], rd[0], irq_cap}), 16'h0005);
    // pwm with single pulse also selected
    axw(8'h04, 8'h04);
    axw(8'h0C, 8'h10);
    axw(8'h08, 8'h00);
    axw(8'h0C, 8'h10);
    axw(8'h10, 8'h02);
    axw(8'h14, 8'h0D);
    axw(8'h20, 8'h00);
    repeat (200) @(negedge aclk);
    chk(inw(per_len, 40, 42), 16'h0001);
    chk(inw(hi_len, 16, 18), 16'h0001);
    axr(8'h1C);
    chk(16'(rd[1:0]), 16'h0000);
    summarize;
  end
endmodule // tcp_top_tb
